//--- rtl/acc_pkg.sv
/*
 * acc_pkg: constants, types and rate table for the calibration-correction
 * datapath. Assumes a single clock domain and no bus beyond the serial
 * register port of the converter.
 */
package acc_pkg;
   // coefficient and datapath widths
   localparam int COEF_W = 24;
   localparam int PATH_W = 28;
   localparam int CTRL_W = 8;
   localparam int RATE_W = 20;
   // gain is 1 + coef / 2^GAIN_FRAC, so coef 0 means unity
   localparam int GAIN_FRAC = 23;
   // clock and pipeline depth
   localparam int MCLK_PERIOD_NS = 5;
   localparam int PIPE_LAT = 5;
   // control register fields
   localparam int BIT_SELF_OFS = 1;
   localparam int BIT_SELF_GAIN = 2;
   localparam int BIT_SYS_OFS = 3;
   localparam int BIT_SYS_GAIN = 4;
   localparam logic [CTRL_W-1:0] CTRL_RST = 8'h1E;
   localparam logic [COEF_W-1:0] COEF_RST = 24'h000000;
   localparam logic [COEF_W-1:0] SAT_MAX = 24'h7FFFFF;
   localparam logic [COEF_W-1:0] SAT_MIN = 24'h800000;

   // register selector on the serial port
   typedef enum logic [1:0] {
      ACC_SEL_CTRL = 2'h0,
      ACC_SEL_SYS_GAIN = 2'h1,
      ACC_SEL_SELF_OFS = 2'h2,
      ACC_SEL_SELF_GAIN = 2'h3
   } acc_sel_e;

   // sample carrier between pipeline stages
   typedef struct packed {
      logic valid;
      logic signed [PATH_W-1:0] data;
   } acc_smp_s;

   // output data rate in thousandths of a sample per second, 0 if none
   function automatic logic [RATE_W-1:0] acc_rate(input logic line_frequency_select,
         input logic cont, input logic [2:0] code);
      logic [RATE_W-1:0] r;
      r = 20'h00000;
      if (cont && !code[2]) begin
         r = 20'h00000;
      end else if (cont) begin
         unique case ({line_frequency_select, code[1:0]})
            3'h0: r = 20'h0EA60; // 60
            3'h1: r = 20'h1D4C0; // 120
            3'h2: r = 20'h3A980; // 240
            3'h3: r = 20'h75300; // 480
            3'h4: r = 20'h0C350; // 50
            3'h5: r = 20'h186A0; // 100
            3'h6: r = 20'h30D40; // 200
            default: r = 20'h61A80; // 400
         endcase
      end else begin
         unique case ({line_frequency_select, code})
            4'h0: r = 20'h003E8; // 1
            4'h1: r = 20'h009C4; // 2.5
            4'h2: r = 20'h01388; // 5
            4'h3: r = 20'h02710; // 10
            4'h4: r = 20'h03A98; // 15
            4'h5: r = 20'h07530; // 30
            4'h6: r = 20'h0EA60; // 60
            4'h7: r = 20'h1D4C0; // 120
            4'h8: r = 20'h00341; // 0.833
            4'h9: r = 20'h00820; // 2.08
            4'hA: r = 20'h0104A; // 4.17
            4'hB: r = 20'h0208A; // 8.33
            4'hC: r = 20'h030D4; // 12.5
            4'hD: r = 20'h061A8; // 25
            4'hE: r = 20'h0C350; // 50
            default: r = 20'h186A0; // 100
         endcase
      end
      return r;
   endfunction
endpackage

//--- rtl/acc_gain_stage.sv
/*
 * acc_gain_stage: one registered gain correction, x * (1 + coef/2^23),
 * rounded to nearest. Assumes the caller keeps |x| within PATH_W-1 bits
 * so the doubled value still fits PATH_W.
 */
`timescale 1ns/1ps
`default_nettype none
module acc_gain_stage (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // sample in and coefficient
   input wire acc_pkg::acc_smp_s smp_in,
   input wire logic [acc_pkg::COEF_W-1:0] coef,
   input wire logic bypass,
   // sample out
   output var acc_pkg::acc_smp_s smp_out
);
   localparam int PW = acc_pkg::PATH_W + acc_pkg::COEF_W;
   localparam logic signed [PW-1:0] HALF = PW'(64'h400000);
   logic signed [PW-1:0] prod;
   logic signed [PW-1:0] rnd;
   logic signed [acc_pkg::PATH_W-1:0] scaled_nxt;

   // rounding before the shift keeps the error under one lsb
   always_comb begin
      prod = PW'(smp_in.data) * PW'($signed(coef));
      rnd = (prod + HALF) >>> acc_pkg::GAIN_FRAC;
      scaled_nxt = smp_in.data + rnd[acc_pkg::PATH_W-1:0];
   end

   // pipeline register; bypass passes the sample unchanged
   always_ff @(posedge clk) begin
      if (rst) begin
         smp_out <= '0;
      end else if (ce) begin
         smp_out.valid <= smp_in.valid;
         smp_out.data <= bypass ? smp_in.data : scaled_nxt;
      end
   end

   bypass_pass_a: assert property (@(posedge clk) disable iff (rst)
      ce && bypass |=> smp_out.data == $past(smp_in.data))
      else $error("bypassed gain stage altered the sample");

   unity_gain_a: assert property (@(posedge clk) disable iff (rst)
      ce && !bypass && coef == 24'h000000
      |=> smp_out.data == $past(smp_in.data))
      else $error("zero coefficient did not give unity gain");
endmodule // acc_gain_stage
`default_nettype wire

//--- rtl/acc_correct.sv
/*
 * acc_correct: calibration-correction datapath with its coefficient and
 * control registers, reached through the serial register port bit by bit.
 * Assumes the serial front end and calibration engine run on MCLK, so their
 * strobes need no synchroniser; the system offset value comes from outside.
 */
// Contract
// - system gain register, 24 bits, msb first
// - system gain kept until rewrite or calibration
// - system gain applied unless its bypass set
// - system gain reaches 2x within 2 lsb
// - self offset register, 24 bits, persistent
// - self offset subtracted unless bypassed
// - self offset is first correction
// - self gain register, 24 bits, persistent
// - self gain writes ignored during calibration
// - self gain applied before system corrections
// - self gain reaches 2x within 2 lsb
// - rate table for 60 Hz line setting
// - rate table for 50 Hz line setting
// - system offset between self and system gain
// - final result saturates, never wraps
// - all four bypass bits reset to one
`timescale 1ns/1ps
`default_nettype none
module acc_correct (
   // clock, reset, enable
   input wire logic MCLK,
   input wire logic RST,
   input wire logic CE,
   // serial register port
   input wire logic [1:0] REG_SEL,
   input wire logic REG_SHIFT_IN,
   input wire logic REG_DIN,
   input wire logic REG_COMMIT,
   input wire logic REG_CAPTURE,
   input wire logic REG_SHIFT_OUT,
   output logic REG_DOUT,
   // calibration engine
   input wire logic CAL_BUSY,
   input wire logic SELF_CAL_DONE,
   input wire logic [acc_pkg::COEF_W-1:0] SELF_CAL_OFS,
   input wire logic [acc_pkg::COEF_W-1:0] SELF_CAL_GAIN,
   input wire logic SYS_CAL_DONE,
   input wire logic [acc_pkg::COEF_W-1:0] SYS_CAL_GAIN,
   input wire logic [acc_pkg::COEF_W-1:0] SYS_OFFSET,
   // conversion data
   input wire logic RAW_VALID,
   input wire logic [acc_pkg::COEF_W-1:0] RAW_DATA,
   input wire logic UNIPOLAR,
   output logic DATA_VALID,
   output logic [acc_pkg::COEF_W-1:0] DATA_OUT,
   // rate selection
   input wire logic LINE_FREQUENCY_SELECT,
   input wire logic CONTINUOUS,
   input wire logic [2:0] RATE_CODE,
   output logic [acc_pkg::RATE_W-1:0] RATE_MSPS,
   output logic RATE_OK
);
   localparam int CW = acc_pkg::COEF_W;
   localparam int PW = acc_pkg::PATH_W;
   localparam logic signed [PW-1:0] SAT_HI = PW'(64'h7FFFFF);
   localparam logic signed [PW-1:0] SAT_LO = -PW'(64'h800000);

   logic [CW-1:0] shift_in_r;
   logic [CW-1:0] shift_out_r;
   logic [acc_pkg::CTRL_W-1:0] calibration_control_register;
   logic [CW-1:0] system_gain_coefficient;
   logic [CW-1:0] self_offset_coefficient;
   logic [CW-1:0] self_gain_coefficient;
   logic self_offset_bypass;
   logic self_gain_bypass;
   logic system_offset_bypass;
   logic system_gain_bypass;
   acc_pkg::acc_smp_s s1_r, s2, s3_r, s4;
   logic signed [PW:0] fin_nxt;

   function automatic logic hit(input logic [1:0] sel,
         input acc_pkg::acc_sel_e want);
      return sel == want;
   endfunction

   assign self_offset_bypass =
      calibration_control_register[acc_pkg::BIT_SELF_OFS];
   assign self_gain_bypass =
      calibration_control_register[acc_pkg::BIT_SELF_GAIN];
   assign system_offset_bypass =
      calibration_control_register[acc_pkg::BIT_SYS_OFS];
   assign system_gain_bypass =
      calibration_control_register[acc_pkg::BIT_SYS_GAIN];

   // write shifter, msb arrives first
   always_ff @(posedge MCLK) begin
      if (RST) begin
         shift_in_r <= acc_pkg::COEF_RST;
      end else if (CE && REG_SHIFT_IN) begin
         shift_in_r <= {shift_in_r[CW-2:0], REG_DIN};
      end
   end

   // read shifter; capturing copies, never alters the source
   always_ff @(posedge MCLK) begin
      if (RST) begin
         shift_out_r <= acc_pkg::COEF_RST;
      end else if (CE && REG_CAPTURE) begin
         unique case (acc_pkg::acc_sel_e'(REG_SEL))
            acc_pkg::ACC_SEL_CTRL:
               shift_out_r <= {calibration_control_register, 16'h0000};
            acc_pkg::ACC_SEL_SYS_GAIN: shift_out_r <= system_gain_coefficient;
            acc_pkg::ACC_SEL_SELF_OFS: shift_out_r <= self_offset_coefficient;
            acc_pkg::ACC_SEL_SELF_GAIN: shift_out_r <= self_gain_coefficient;
         endcase
      end else if (CE && REG_SHIFT_OUT) begin
         shift_out_r <= {shift_out_r[CW-2:0], 1'b0};
      end
   end
   assign REG_DOUT = shift_out_r[CW-1];

   // control byte: bypass bits come up set so raw data passes at first
   always_ff @(posedge MCLK) begin
      if (RST) begin
         calibration_control_register <= acc_pkg::CTRL_RST;
      end else if (CE && REG_COMMIT
            && hit(REG_SEL, acc_pkg::ACC_SEL_CTRL)) begin
         calibration_control_register <= shift_in_r[acc_pkg::CTRL_W-1:0];
      end
   end

   // system gain; a finished calibration wins over a host write
   always_ff @(posedge MCLK) begin
      if (RST) begin
         system_gain_coefficient <= acc_pkg::COEF_RST;
      end else if (CE && SYS_CAL_DONE) begin
         system_gain_coefficient <= SYS_CAL_GAIN;
      end else if (CE && REG_COMMIT
            && hit(REG_SEL, acc_pkg::ACC_SEL_SYS_GAIN)) begin
         system_gain_coefficient <= shift_in_r;
      end
   end

   // self offset
   always_ff @(posedge MCLK) begin
      if (RST) begin
         self_offset_coefficient <= acc_pkg::COEF_RST;
      end else if (CE && SELF_CAL_DONE) begin
         self_offset_coefficient <= SELF_CAL_OFS;
      end else if (CE && REG_COMMIT
            && hit(REG_SEL, acc_pkg::ACC_SEL_SELF_OFS)) begin
         self_offset_coefficient <= shift_in_r;
      end
   end

   // self gain; host writes dropped while a calibration runs
   always_ff @(posedge MCLK) begin
      if (RST) begin
         self_gain_coefficient <= acc_pkg::COEF_RST;
      end else if (CE && SELF_CAL_DONE) begin
         self_gain_coefficient <= SELF_CAL_GAIN;
      end else if (CE && REG_COMMIT && !CAL_BUSY
            && hit(REG_SEL, acc_pkg::ACC_SEL_SELF_GAIN)) begin
         self_gain_coefficient <= shift_in_r;
      end
   end

   // stage 1: self offset subtraction, first in the chain
   always_ff @(posedge MCLK) begin
      if (RST) begin
         s1_r <= '0;
      end else if (CE) begin
         s1_r.valid <= RAW_VALID;
         s1_r.data <= self_offset_bypass ? PW'($signed(RAW_DATA))
            : PW'($signed(RAW_DATA))
            - PW'($signed(self_offset_coefficient));
      end
   end

   // stage 2: self gain, ahead of any system correction
   acc_gain_stage u_self_gain (
      .clk(MCLK),
      .rst(RST),
      .ce(CE),
      .smp_in(s1_r),
      .coef(self_gain_coefficient),
      .bypass(self_gain_bypass),
      .smp_out(s2)
   );

   // stage 3: system offset between the two gains
   always_ff @(posedge MCLK) begin
      if (RST) begin
         s3_r <= '0;
      end else if (CE) begin
         s3_r.valid <= s2.valid;
         s3_r.data <= system_offset_bypass ? s2.data
            : s2.data - PW'($signed(SYS_OFFSET));
      end
   end

   // stage 4: system gain
   acc_gain_stage u_sys_gain (
      .clk(MCLK),
      .rst(RST),
      .ce(CE),
      .smp_in(s3_r),
      .coef(system_gain_coefficient),
      .bypass(system_gain_bypass),
      .smp_out(s4)
   );

   // stage 5: unipolar doubling, then clamp; one spare bit keeps the
   // doubled value of an extreme sample from wrapping before the clamp
   always_comb begin
      fin_nxt = UNIPOLAR ? {s4.data, 1'b0}
         : {s4.data[PW-1], s4.data};
      if (fin_nxt > (PW+1)'(SAT_HI)) begin
         fin_nxt = (PW+1)'(SAT_HI);
      end else if (fin_nxt < (PW+1)'(SAT_LO)) begin
         fin_nxt = (PW+1)'(SAT_LO);
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         DATA_VALID <= 1'b0;
         DATA_OUT <= acc_pkg::COEF_RST;
      end else if (CE) begin
         DATA_VALID <= s4.valid;
         if (s4.valid) begin
            DATA_OUT <= fin_nxt[CW-1:0];
         end
      end
   end

   // rate lookup, registered; low codes have no continuous rate
   always_ff @(posedge MCLK) begin
      if (RST) begin
         RATE_MSPS <= 20'h00000;
         RATE_OK <= 1'b0;
      end else if (CE) begin
         RATE_MSPS <= acc_pkg::acc_rate(LINE_FREQUENCY_SELECT, CONTINUOUS,
            RATE_CODE);
         RATE_OK <= !(CONTINUOUS && !RATE_CODE[2]);
      end
   end

   reset_bypass_a: assert property (@(posedge MCLK)
      $rose(!RST) |-> calibration_control_register[4:1] == 4'hF)
      else $error("bypass bits not set after reset");

   busy_write_drop_a: assert property (@(posedge MCLK)
      disable iff (RST)
      CE && CAL_BUSY && !SELF_CAL_DONE
      |=> $stable(self_gain_coefficient))
      else $error("self gain changed during calibration");

   sys_cal_load_a: assert property (@(posedge MCLK) disable iff (RST)
      CE && SYS_CAL_DONE
      |=> system_gain_coefficient == $past(SYS_CAL_GAIN))
      else $error("system calibration result not stored");

   capture_keep_a: assert property (@(posedge MCLK) disable iff (RST)
      CE && REG_CAPTURE && !REG_COMMIT && !SELF_CAL_DONE && !SYS_CAL_DONE
      |=> $stable(system_gain_coefficient)
      && $stable(self_offset_coefficient))
      else $error("register read disturbed a coefficient");

   // compare against the value held at the capture edge, not a newer one
   msb_first_a: assert property (@(posedge MCLK) disable iff (RST)
      CE && REG_CAPTURE && REG_SEL == 2'h1
      |=> REG_DOUT == $past(system_gain_coefficient[CW-1]))
      else $error("read did not present the msb first");

   out_clamp_a: assert property (@(posedge MCLK) disable iff (RST)
      CE && s4.valid && s4.data > SAT_HI && !UNIPOLAR
      |=> DATA_OUT == acc_pkg::SAT_MAX)
      else $error("positive overflow not clamped");

   all_bypass_a: assert property (@(posedge MCLK) disable iff (RST)
      CE && RAW_VALID && !UNIPOLAR && calibration_control_register[4:1] == 4'hF
      ##1 CE [*4] |=> DATA_VALID && DATA_OUT == $past(RAW_DATA, 5))
      else $error("bypassed chain did not pass raw data in five cycles");

   offset_first_a: assert property (@(posedge MCLK) disable iff (RST)
      CE && !self_offset_bypass |=> s1_r.data
      == PW'($signed($past(RAW_DATA)))
      - PW'($signed($past(self_offset_coefficient))))
      else $error("self offset not applied first");

   rate_cont_a: assert property (@(posedge MCLK) disable iff (RST)
      CE && CONTINUOUS && !RATE_CODE[2]
      |=> !RATE_OK && RATE_MSPS == 20'h00000)
      else $error("continuous rate offered for a low code");
endmodule // acc_correct
`default_nettype wire

//--- sim/acc_host.sv
/*
 * acc_host: behavioural serial host that writes and reads the coefficient
 * and control registers over the bit-serial register port.
 * Assumes one clock shared with the converter; it drives just after edges.
 */
`timescale 1ns/1ps
`default_nettype none
module acc_host (
   // clock
   input wire logic clk,
   // register port toward the converter
   output logic [1:0] sel,
   output logic shift_in,
   output logic din,
   output logic commit,
   output logic capture,
   output logic shift_out,
   input wire logic dout
);
   // idle levels from time zero
   initial begin
      sel = 2'h0;
      shift_in = 1'b0;
      din = 1'b0;
      commit = 1'b0;
      capture = 1'b0;
      shift_out = 1'b0;
   end

   // whole 24-bit word msb first, then one commit pulse
   task automatic wr(input logic [1:0] s, input logic [23:0] v);
      @(posedge clk);
      #1;
      sel = s;
      for (int i = 23; i >= 0; i--) begin
         shift_in = 1'b1;
         din = v[i];
         @(posedge clk);
         #1;
      end
      shift_in = 1'b0;
      din = ~din; // released line must not keep showing the last bit
      commit = 1'b1;
      @(posedge clk);
      #1;
      commit = 1'b0;
   endtask

   // capture, then take one bit a cycle while shifting 23 times
   task automatic rd(input logic [1:0] s, output logic [23:0] v);
      @(posedge clk);
      #1;
      sel = s;
      capture = 1'b1;
      @(posedge clk);
      #1;
      capture = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         v[i] = dout;
         shift_out = (i > 0);
         if (i > 0) begin
            @(posedge clk);
            #1;
         end
      end
   endtask
endmodule // acc_host
`default_nettype wire

//--- sim/acc_correct_bench.sv
/*
 * acc_correct_bench: self-checking bench for the correction datapath,
 * its registers and the rate lookup.
 * Assumes acc_host owns the register port; all else is driven here.
 */
`timescale 1ns/1ps
`default_nettype none
module acc_correct_bench;
   logic mclk, rst, ce, cal_busy, self_done, sys_done, raw_valid, uni;
   logic [1:0] reg_sel;
   logic sh_in, din, commit, capture, sh_out, dout, valid_o, line_frequency_select, cont;
   logic rate_ok;
   logic [2:0] code;
   logic [19:0] rate;
   logic [23:0] raw, data_o, sys_ofs, s_ofs_m, s_gain_m, y_gain_m, got, pat;
   logic [23:0] sofs, sgn, sysg;
   logic [7:0] ctl;
   logic [7:0] ctab [6] = '{8'h1E, 8'h1C, 8'h1A, 8'h18, 8'h10, 8'h00};
   logic [19:0] sgl [16] = '{20'h003E8, 20'h009C4, 20'h01388, 20'h02710,
      20'h03A98, 20'h07530, 20'h0EA60, 20'h1D4C0, 20'h00341, 20'h00820,
      20'h0104A, 20'h0208A, 20'h030D4, 20'h061A8, 20'h0C350, 20'h186A0};
   logic [19:0] ctb [8] = '{20'h0EA60, 20'h1D4C0, 20'h3A980, 20'h75300,
      20'h0C350, 20'h186A0, 20'h30D40, 20'h61A80};
   int n_checks = 0;
   int n_mismatch = 0;

   acc_correct acc_correct_inst (.MCLK(mclk), .RST(rst), .CE(ce),
      .REG_SEL(reg_sel), .REG_SHIFT_IN(sh_in), .REG_DIN(din),
      .REG_COMMIT(commit), .REG_CAPTURE(capture), .REG_SHIFT_OUT(sh_out),
      .REG_DOUT(dout), .CAL_BUSY(cal_busy), .SELF_CAL_DONE(self_done),
      .SELF_CAL_OFS(s_ofs_m), .SELF_CAL_GAIN(s_gain_m),
      .SYS_CAL_DONE(sys_done), .SYS_CAL_GAIN(y_gain_m),
      .SYS_OFFSET(sys_ofs), .RAW_VALID(raw_valid), .RAW_DATA(raw),
      .UNIPOLAR(uni), .DATA_VALID(valid_o), .DATA_OUT(data_o),
      .LINE_FREQUENCY_SELECT(line_frequency_select), .CONTINUOUS(cont), .RATE_CODE(code),
      .RATE_MSPS(rate), .RATE_OK(rate_ok));

   acc_host acc_host_inst (.clk(mclk), .sel(reg_sel), .shift_in(sh_in),
      .din(din), .commit(commit), .capture(capture), .shift_out(sh_out),
      .dout(dout));

   // 200 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic chk(input logic [23:0] g, input logic [23:0] e,
         input string what);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, g, e);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // one gain step, 1 + c/2^23, rounded half up
   function automatic longint gain(input longint x, input logic [23:0] c);
      return x + ((x * longint'(signed'(c)) + 64'sh400000) >>> 23);
   endfunction

   // reference chain: self ofs, self gain, sys ofs, sys gain, x2, clamp
   function automatic logic [23:0] model(input logic [23:0] r);
      longint x;
      x = longint'(signed'(r));
      if (!ctl[acc_pkg::BIT_SELF_OFS]) x = x - longint'(signed'(sofs));
      if (!ctl[acc_pkg::BIT_SELF_GAIN]) x = gain(x, sgn);
      if (!ctl[acc_pkg::BIT_SYS_OFS]) x = x - longint'(signed'(sys_ofs));
      if (!ctl[acc_pkg::BIT_SYS_GAIN]) x = gain(x, sysg);
      if (uni) x = x * 2;
      if (x > longint'(signed'(acc_pkg::SAT_MAX))) x = 64'sh7FFFFF;
      if (x < longint'(signed'(acc_pkg::SAT_MIN))) x = -64'sh800000;
      return x[23:0];
   endfunction

   // one sample in, result exactly PIPE_LAT edges later
   task automatic smp(input logic [23:0] r);
      logic [23:0] e;
      e = model(r);
      @(posedge mclk);
      #1;
      raw = r;
      raw_valid = 1'b1;
      @(posedge mclk);
      #1;
      raw_valid = 1'b0;
      raw = ~r;
      // the taking edge is already behind us; stop one edge short
      repeat (acc_pkg::PIPE_LAT - 2) @(posedge mclk);
      #1;
      chk({23'h000000, valid_o}, 24'h000000, "early valid");
      @(posedge mclk);
      #1;
      chk({23'h000000, valid_o}, 24'h000001, "valid");
      chk(data_o, e, "data");
   endtask

   task automatic setc(input logic [7:0] c);
      ctl = c;
      acc_host_inst.wr(2'h0, {16'h0000, c});
   endtask

   // a hang ends the run as a failure
   initial begin
      #50000;
      n_mismatch++;
      test_done;
   end

   // main sequence
   initial begin
      {rst, ce} = 2'h3;
      {cal_busy, self_done, sys_done, raw_valid, uni} = 5'h00;
      {line_frequency_select, cont, code} = 5'h00;
      raw = 24'h000000;
      sys_ofs = 24'h000050;
      s_ofs_m = 24'h000333;
      s_gain_m = 24'hE00000;
      y_gain_m = 24'h200000;
      ctl = 8'h1E;
      {sofs, sgn, sysg} = 72'h0;
      repeat (5) @(posedge mclk);
      #1;
      rst = 1'b0;
      acc_host_inst.rd(2'h0, got);
      chk(got, 24'h1E0000, "control reset");
      smp(24'h012345);
      for (int s = 1; s < 4; s++) begin
         pat = 24'hA5C381 ^ {22'h000000, s[1:0]};
         acc_host_inst.rd(s[1:0], got);
         chk(got, 24'h000000, "coef reset");
         acc_host_inst.wr(s[1:0], pat);
         acc_host_inst.rd(s[1:0], got);
         chk(got, pat, "coef write");
         acc_host_inst.rd(s[1:0], got);
         chk(got, pat, "coef reread");
      end
      cal_busy = 1'b1;
      acc_host_inst.wr(2'h3, 24'h123456);
      cal_busy = 1'b0;
      acc_host_inst.rd(2'h3, got);
      chk(got, 24'hA5C382, "busy write");
      {sysg, sofs, sgn} = {24'hC00000, 24'h000100, 24'h400000};
      acc_host_inst.wr(2'h1, sysg);
      acc_host_inst.wr(2'h2, sofs);
      acc_host_inst.wr(2'h3, sgn);
      for (int k = 0; k < 6; k++) begin
         setc(ctab[k]);
         smp(24'h012345);
         smp(24'hF00000);
      end
      sysg = 24'h7FFFFF;
      acc_host_inst.wr(2'h1, sysg);
      setc(8'h0E);
      smp(24'h600000);
      smp(24'hA00000);
      setc(8'h1E);
      uni = 1'b1;
      smp(24'h500000);
      smp(24'h100000);
      uni = 1'b0;
      // zero system gain is unity; enable low freezes every stage
      sysg = 24'h000000;
      acc_host_inst.wr(2'h1, sysg);
      setc(8'h0E);
      @(posedge mclk);
      #1;
      raw = 24'h0ABCDE;
      raw_valid = 1'b1;
      @(posedge mclk);
      #1;
      raw_valid = 1'b0;
      ce = 1'b0;
      repeat (6) @(posedge mclk);
      #1;
      chk({23'h000000, valid_o}, 24'h000000, "frozen valid");
      ce = 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      chk({23'h000000, valid_o}, 24'h000001, "thawed valid");
      chk(data_o, 24'h0ABCDE, "thawed data");
      // calibration results replace host values
      {sys_done, self_done} = 2'h3;
      @(posedge mclk);
      #1;
      {sys_done, self_done} = 2'h0;
      acc_host_inst.rd(2'h1, got);
      chk(got, y_gain_m, "sys cal");
      acc_host_inst.rd(2'h2, got);
      chk(got, s_ofs_m, "self cal ofs");
      acc_host_inst.rd(2'h3, got);
      chk(got, s_gain_m, "self cal gain");
      for (int k = 0; k < 32; k++) begin
         {line_frequency_select, cont, code} = k[4:0];
         @(posedge mclk);
         #1;
         pat = cont ? (code[2] ? {4'h0, ctb[{line_frequency_select, code[1:0]}]} : 24'h0)
            : {4'h0, sgl[{line_frequency_select, code}]};
         chk({4'h0, rate}, pat, "rate");
         chk({23'h0, rate_ok}, {23'h0, !(cont && !code[2])}, "ok");
      end
      // reset in mid-run brings back the bypass bits and zero coefficients
      rst = 1'b1;
      @(posedge mclk);
      #1;
      rst = 1'b0;
      acc_host_inst.rd(2'h0, got);
      chk(got, 24'h1E0000, "control after reset");
      acc_host_inst.rd(2'h1, got);
      chk(got, 24'h000000, "sys gain after reset");
      test_done;
   end
endmodule // acc_correct_bench
`default_nettype wire
